// ===== rtl/cbw_bus_if.sv
// Processor-side memory bus interface: lanes, waits and request withdrawal
//
// Functional notes
// - Endian affects only halfword and byte transfers
// - Halfword store duplicated on both halves
// - Byte store copied onto all lanes
// - Read lane from endian, size, address
// - Unused read lanes are ignored
// - Bus cycle completes on enabled edge
// - Extension only in whole clock periods
// - Low enable stalls both buses together
// - Request leads data by one bus cycle
// - Next address may show during wait
// - Pending request may change while waiting
// - Committed access never altered or withdrawn
// - Alteration only during waited extension
// - Alteration drops request flags only; address, direction and size held
// - Cycle type: N, S, internal, coprocessor
// - Data exchanged at end of next cycle
`timescale 1ns/10ps
module cbw_bus_if
    import cbw_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    input  wire logic        bus_cycle_enable,
    input  wire logic        endian_select,
    // Core-side instruction request
    input  wire logic        core_ireq,
    input  wire logic        core_instr_sequential,
    input  wire logic [31:0] core_iaddr,
    // Core-side data request
    input  wire logic        core_dreq,
    input  wire logic        core_data_sequential,
    input  wire logic        core_dcop,
    input  wire logic        core_dwrite,
    input  wire logic [1:0]  core_dsize,
    input  wire logic        core_data_burst_lookahead,
    input  wire logic        core_dspec,
    input  wire logic [31:0] core_daddr,
    input  wire logic [31:0] core_wdata,
    // Core asks to drop its next uncommitted request
    input  wire logic        core_withdraw,
    output logic             core_accept,
    output logic [31:0]      core_rdata,
    output logic             core_rvalid,
    // Memory side
    output logic [31:0]      instr_address,
    output logic             instr_request_n,
    output logic             instr_sequential,
    output logic [31:0]      data_address,
    output logic             data_request_n,
    output logic             data_sequential,
    output logic             data_burst_lookahead,
    output logic             data_speculative_n,
    output logic             data_write,
    output logic [1:0]       data_size,
    output logic [31:0]      wdata,
    input  wire logic [31:0] rdata
);
    // Uncommitted request registers, presented to memory
    logic [31:0] iaddr_reg;
    logic        ireq_n_reg;
    logic        instr_sequential_reg;
    logic [31:0] daddr_reg;
    logic        dreq_n_reg;
    logic        data_sequential_reg;
    logic        data_burst_lookahead_reg;
    logic        dspec_n_reg;
    logic        dwrite_reg;
    logic [1:0]  dsize_reg;
    logic [31:0] dwdata_reg;
    // Committed data phase
    cbw_phase_t  phase_reg;
    logic        ph_write_reg;
    logic [1:0]  ph_size_reg;
    logic [1:0]  ph_addr_reg;
    logic [31:0] wdata_reg;
    logic [31:0] rdata_reg;
    logic        rvalid_reg;
    logic        waited_reg;
    logic [31:0] rep_wdata;
    logic [31:0] sel_rdata;
    logic [1:0]  core_cyc;
    logic        data_xfer;

    // Cycle type from request and coprocessor flag
    always_comb begin
        if (core_dcop)
            core_cyc = CBW_CYC_COP;
        else if (!core_dreq)
            core_cyc = CBW_CYC_INT;
        else if (core_data_sequential)
            core_cyc = CBW_CYC_SEQ;
        else
            core_cyc = CBW_CYC_NSEQ;
    end

    // New requests load only on enabled edges; one enable gates both buses
    assign core_accept = bus_cycle_enable;

    // Committed phase moves a data beat only for N and S cycles
    assign data_xfer = (phase_reg == CBW_DATA);

    cbw_wr_lanes u_wr (
        .size     (core_dsize),
        .data_in  (core_wdata),
        .data_out (rep_wdata)
    );

    cbw_rd_lanes u_rd (
        .size          (ph_size_reg),
        .addr_lo       (ph_addr_reg),
        .endian_select (endian_select),
        .rdata         (rdata),
        .data_out      (sel_rdata)
    );

    // Tracks whether the current bus cycle has been stretched by a low enable
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            waited_reg <= 1'b0;
        end else begin
            waited_reg <= !bus_cycle_enable;
        end
    end

    // Request outputs: loaded on enabled edges; during a wait the pending
    // request may only be dropped, since the next edge-with-enable commits it
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            iaddr_reg   <= CBW_ADDR_RST;
            ireq_n_reg  <= 1'b1;
            instr_sequential_reg    <= 1'b0;
            daddr_reg   <= CBW_ADDR_RST;
            dreq_n_reg  <= 1'b1;
            data_sequential_reg    <= 1'b0;
            data_burst_lookahead_reg   <= 1'b0;
            dspec_n_reg <= 1'b1;
            dwrite_reg  <= 1'b0;
            dsize_reg   <= CBW_SIZE_WORD;
            dwdata_reg  <= CBW_DATA_RST;
        end else if (bus_cycle_enable) begin
            // Next access broadcast a bus cycle ahead of its data
            iaddr_reg   <= core_iaddr;
            ireq_n_reg  <= !core_ireq;
            instr_sequential_reg    <= core_instr_sequential;
            daddr_reg   <= core_daddr;
            {dreq_n_reg, data_sequential_reg} <= core_cyc;
            data_burst_lookahead_reg   <= core_data_burst_lookahead & core_dreq & !core_dcop;
            dspec_n_reg <= !core_dspec;
            dwrite_reg  <= core_dwrite;
            dsize_reg   <= core_dsize;
            dwdata_reg  <= rep_wdata;
        end else if (core_withdraw) begin
            // Uncommitted request dropped during the waited extension
            ireq_n_reg  <= 1'b1;
            instr_sequential_reg    <= 1'b0;
            dreq_n_reg  <= 1'b1;
            data_sequential_reg    <= 1'b0;
            data_burst_lookahead_reg   <= 1'b0;
            dspec_n_reg <= 1'b1;
        end
    end

    // Committed access captured into the data phase; never changed afterward
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg    <= CBW_IDLE;
            ph_write_reg <= 1'b0;
            ph_size_reg  <= CBW_SIZE_WORD;
            ph_addr_reg  <= 2'h0;
            wdata_reg    <= CBW_DATA_RST;
        end else if (bus_cycle_enable) begin
            // Sampled request commits; the controller acts only on N and S
            if (!dreq_n_reg) begin
                phase_reg    <= CBW_DATA;
                ph_write_reg <= dwrite_reg;
                ph_size_reg  <= dsize_reg;
                ph_addr_reg  <= daddr_reg[1:0];
                wdata_reg    <= dwdata_reg;
            end else begin
                phase_reg    <= CBW_IDLE;
            end
        end
    end

    // Read beat captured at the enabled edge that ends the data cycle
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_reg  <= CBW_DATA_RST;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= bus_cycle_enable & data_xfer & !ph_write_reg;
            if (bus_cycle_enable && data_xfer && !ph_write_reg)
                rdata_reg <= sel_rdata;
        end
    end

    assign instr_address        = iaddr_reg;
    assign instr_request_n      = ireq_n_reg;
    assign instr_sequential     = instr_sequential_reg;
    assign data_address         = daddr_reg;
    assign data_request_n       = dreq_n_reg;
    assign data_sequential      = data_sequential_reg;
    assign data_burst_lookahead = data_burst_lookahead_reg;
    assign data_speculative_n   = dspec_n_reg;
    assign data_write           = dwrite_reg;
    assign data_size            = dsize_reg;
    // Store data only changes on enabled edges, so it stays put through waits
    assign wdata                = wdata_reg;
    assign core_rdata           = rdata_reg;
    assign core_rvalid          = rvalid_reg;

    // A committed access reaches the data phase exactly as it was sampled
    a_commit_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bus_cycle_enable && !data_request_n |=>
        phase_reg == CBW_DATA && ph_addr_reg == $past(data_address[1:0]) &&
        ph_size_reg == $past(data_size) && ph_write_reg == $past(data_write))
        else $error("committed request altered");
    a_addr_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) |-> $stable(data_address) && $stable(instr_address))
        else $error("address changed during wait");
    a_wdata_hold: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) |-> $stable(wdata))
        else $error("write data moved during wait");
    a_drop_only: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) && $changed(data_request_n) |-> data_request_n)
        else $error("request raised during wait");
    a_lookahead_req: assert property (@(posedge sys_clk) disable iff (sys_rst)
        data_burst_lookahead |-> !data_request_n)
        else $error("lookahead without request");
    a_data_phase: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bus_cycle_enable && !data_request_n && !data_write ##1 bus_cycle_enable[*1] |->
        ##1 core_rvalid)
        else $error("read beat not returned next bus cycle");
    a_no_internal: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bus_cycle_enable && data_request_n ##1 bus_cycle_enable |-> ##1 !core_rvalid)
        else $error("beat for internal cycle");
    a_rvalid_en: assert property (@(posedge sys_clk) disable iff (sys_rst)
        core_rvalid |-> $past(bus_cycle_enable))
        else $error("beat without enabled edge");

    // Waited clocks leave the committed data phase untouched, so stretching is whole periods
    a_phase_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
        waited_reg |-> $stable(phase_reg) && $stable(ph_addr_reg) &&
        $stable(ph_size_reg) && $stable(wdata_reg))
        else $error("data phase moved in a waited clock");

    // No read beat can complete on a waited clock
    a_wait_beat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        waited_reg |-> !core_rvalid)
        else $error("beat after waited clock");

    // Instruction request may only be dropped while waiting
    a_instr_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) && $changed(instr_request_n) |-> instr_request_n)
        else $error("instruction request raised during wait");

    // Sequential hint on the instruction side only falls during a wait
    a_instr_sequential_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) && $changed(instr_sequential) |-> !instr_sequential)
        else $error("instruction sequential raised during wait");

    // Burst lookahead only falls during a wait
    a_more_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) && $changed(data_burst_lookahead) |-> !data_burst_lookahead)
        else $error("lookahead raised during wait");

    // Speculative flag only returns to idle during a wait
    a_spec_drop: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) && $changed(data_speculative_n) |-> data_speculative_n)
        else $error("speculative flag raised during wait");

    // Direction and size are not part of what a wait may alter
    a_class_wait: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !$past(bus_cycle_enable) |-> $stable(data_write) && $stable(data_size))
        else $error("access class changed during wait");

    // Coprocessor transfers are shown as type C
    a_cop_type: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bus_cycle_enable && core_dcop |=> data_request_n && data_sequential)
        else $error("coprocessor cycle misencoded");

    // No request and no coprocessor flag gives an internal cycle
    a_int_type: assert property (@(posedge sys_clk) disable iff (sys_rst)
        bus_cycle_enable && !core_dreq && !core_dcop |=> data_request_n && !data_sequential)
        else $error("internal cycle misencoded");

    // A pending byte store already carries four equal lanes
    a_byte_copies: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !data_request_n && data_write && data_size == CBW_SIZE_BYTE |->
        dwdata_reg == {4{dwdata_reg[7:0]}})
        else $error("byte store not replicated");

    // A pending halfword store carries equal halves
    a_half_copies: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !data_request_n && data_write && data_size == CBW_SIZE_HALF |->
        dwdata_reg == {2{dwdata_reg[15:0]}})
        else $error("halfword store not replicated");

    // Read data only moves together with a read beat
    a_rdata_beat: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $changed(core_rdata) |-> core_rvalid)
        else $error("read data moved without a beat");
endmodule

// ===== shared/cbw_pkg.sv
// Constants and types for the processor-side bus wait and lane logic
package cbw_pkg;
    // Transfer size codes
    localparam logic [1:0] CBW_SIZE_BYTE = 2'h0;
    localparam logic [1:0] CBW_SIZE_HALF = 2'h1;
    localparam logic [1:0] CBW_SIZE_WORD = 2'h2;
    // Data cycle type codes as {request_n, sequential}
    localparam logic [1:0] CBW_CYC_NSEQ  = 2'h0;
    localparam logic [1:0] CBW_CYC_SEQ   = 2'h1;
    localparam logic [1:0] CBW_CYC_INT   = 2'h2;
    localparam logic [1:0] CBW_CYC_COP   = 2'h3;
    // Reset values
    localparam logic [31:0] CBW_ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] CBW_DATA_RST = 32'h0000_0000;
    // Data phase tracking
    typedef enum logic [1:0] {CBW_IDLE, CBW_ADDR, CBW_DATA} cbw_phase_t;
endpackage

// ===== rtl/cbw_wr_lanes.sv
// Write data lane replication
`timescale 1ns/10ps
module cbw_wr_lanes
    import cbw_pkg::*;
(
    input  wire logic [1:0]  size,
    input  wire logic [31:0] data_in,
    output logic      [31:0] data_out
);
    // Narrow stores copied to every lane, so memory may pick any copy
    always_comb begin
        unique case (size)
            CBW_SIZE_BYTE: data_out = {4{data_in[7:0]}};
            CBW_SIZE_HALF: data_out = {2{data_in[15:0]}};
            default:       data_out = data_in;
        endcase
    end
endmodule

// ===== rtl/cbw_rd_lanes.sv
// Read data lane selection by endian, size and low address bits
`timescale 1ns/10ps
module cbw_rd_lanes
    import cbw_pkg::*;
(
    input  wire logic [1:0]  size,
    input  wire logic [1:0]  addr_lo,
    input  wire logic        endian_select,
    input  wire logic [31:0] rdata,
    output logic      [31:0] data_out
);
    logic [1:0] lane;
    // Big endian flips lane order; word reads ignore the setting
    always_comb begin
        lane = addr_lo ^ {2{endian_select}};
        unique case (size)
            CBW_SIZE_BYTE: data_out = {24'h0, rdata[8*lane +: 8]};
            CBW_SIZE_HALF: data_out = {16'h0, rdata[16*lane[1] +: 16]};
            default:       data_out = rdata;
        endcase
    end
endmodule

// ===== verification/cbw_mem_model.sv
// Memory controller model for the data side of the bus interface
`timescale 1ns/10ps
module cbw_mem_model
    import cbw_pkg::*;
#(
    parameter logic [31:0] READ_WORD = 32'h8844_2211
)
(
    input  wire logic        sys_clk,
    input  wire logic        bus_cycle_enable,
    input  wire logic        data_request_n,
    input  wire logic        data_write,
    input  wire logic [31:0] wdata,
    output logic      [31:0] rdata,
    output logic      [31:0] last_wdata
);
    logic pend_reg = 1'b0;
    logic wr_reg   = 1'b0;
    // Waited edges must not advance the model, or a stretched cycle would count twice
    always_ff @(posedge sys_clk) begin
        if (bus_cycle_enable) begin
            if (pend_reg && wr_reg) last_wdata <= wdata;
            pend_reg <= !data_request_n;
            wr_reg   <= data_write;
        end
    end
    // Full word for any size; outside a data cycle every bit inverts so stale data never matches
    assign rdata = pend_reg ? READ_WORD : ~READ_WORD;
endmodule

// ===== verification/cbw_bus_if_tb.sv
// Self-checking bench for the bus wait and lane logic
`timescale 1ns/10ps
module cbw_bus_if_tb import cbw_pkg::*;;
    localparam logic [31:0] RW = 32'h8844_2211;
    localparam logic [31:0] WD = 32'hc3a5_5a3c;
    logic        sys_clk, sys_rst, bus_cycle_enable, endian_select, core_ireq, core_instr_sequential;
    logic        core_dreq, core_data_sequential, core_dcop, core_dwrite, core_data_burst_lookahead, core_dspec, core_withdraw;
    logic [1:0]  core_dsize, data_size;
    logic [31:0] core_iaddr, core_daddr, core_wdata, core_rdata, instr_address, data_address;
    logic [31:0] wdata, rdata, last_wdata;
    logic        core_accept, core_rvalid, instr_request_n, instr_sequential, data_request_n;
    logic        data_sequential, data_burst_lookahead, data_speculative_n, data_write;
    int          n_mismatch = 0, comparisons = 0, cycles = 0;

    cbw_bus_if dut (
        .sys_clk, .sys_rst, .bus_cycle_enable, .endian_select, .core_ireq, .core_instr_sequential, .core_iaddr,
        .core_dreq, .core_data_sequential, .core_dcop, .core_dwrite, .core_dsize, .core_data_burst_lookahead, .core_dspec,
        .core_daddr, .core_wdata, .core_withdraw, .core_accept, .core_rdata, .core_rvalid,
        .instr_address, .instr_request_n, .instr_sequential, .data_address, .data_request_n,
        .data_sequential, .data_burst_lookahead, .data_speculative_n, .data_write, .data_size,
        .wdata, .rdata
    );
    cbw_mem_model #(.READ_WORD(RW)) mem (
        .sys_clk, .bus_cycle_enable, .data_request_n, .data_write, .wdata, .rdata, .last_wdata
    );

    // Free-running 4 ns clock
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end

    // Hang guard, well above the roughly 190 cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            finish_test;
        end
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected read lane, worked from the lane tables
    function automatic logic [31:0] lane(input logic [1:0] sz, input logic [1:0] a);
        logic [1:0] b;
        b = endian_select ? ~a : a;
        if (sz == CBW_SIZE_BYTE) return {24'h0, RW[8*b +: 8]};
        if (sz == CBW_SIZE_HALF) return {16'h0, RW[16*b[1] +: 16]};
        return RW;
    endfunction

    // One data access with n waited clocks in its data cycle; withdraw is held up throughout
    task automatic op(input logic w, input logic [1:0] sz, input logic [1:0] a, input int n);
        logic [31:0] wx;
        wx = sz == CBW_SIZE_BYTE ? {4{WD[7:0]}} : sz == CBW_SIZE_HALF ? {2{WD[15:0]}} : WD;
        {core_dreq, core_dwrite, core_dsize, core_withdraw} = {1'b1, w, sz, 1'b1};
        core_daddr = {30'h0000_0040, a};
        @(posedge sys_clk); #1;
        core_dreq = 1'b0;
        chk({data_request_n, data_sequential, data_write, data_size, data_address[1:0]}, {CBW_CYC_NSEQ, w, sz, a});
        @(posedge sys_clk); #1;
        for (int i = 0; i <= n; i++) begin
            if (w) chk(wdata, wx);
            else chk(core_rvalid, 1'b0);
            bus_cycle_enable = (i == n);
            @(posedge sys_clk); #1;
        end
        if (w) chk(last_wdata, wx);
        else begin
            chk(core_rvalid, 1'b1);
            chk(core_rdata, lane(sz, a));
        end
    endtask

    task automatic t_lanes;
        for (int e = 0; e < 2; e++) begin
            endian_select = e[0];
            for (int a = 0; a < 4; a++) begin
                op(1'b0, CBW_SIZE_BYTE, a[1:0], a);
                op(1'b1, CBW_SIZE_BYTE, a[1:0], 3 - a);
                op(1'b0, CBW_SIZE_HALF, {a[1], 1'b0}, a);
                op(1'b1, CBW_SIZE_HALF, {a[1], 1'b0}, 0);
                op(a[0], CBW_SIZE_WORD, 2'h0, 1);
            end
        end
        $display("lanes and waits done");
    endtask

    task automatic t_types;
        {core_dwrite, core_withdraw} = 2'h0;
        for (int i = 0; i < 4; i++) begin
            {core_dreq, core_data_sequential, core_dcop, core_data_burst_lookahead, core_instr_sequential, core_dspec} =
                {!i[1], i[0] & !i[1], i == 3, i == 1, i[0], i == 2};
            @(posedge sys_clk); #1;
            chk({data_request_n, data_sequential, data_burst_lookahead, instr_sequential, data_speculative_n},
                {i[1:0], i == 1, i[0], i != 2});
            {core_dreq, core_data_sequential, core_dcop, core_data_burst_lookahead, core_instr_sequential, core_dspec} = 6'h0;
            repeat (3) @(posedge sys_clk);
            #1;
        end
        $display("cycle types done");
    endtask

    task automatic t_withdraw;
        {core_dreq, core_ireq, core_instr_sequential, core_data_burst_lookahead, core_dspec} = 5'h1f;
        {core_iaddr, core_daddr} = {32'h0000_0100, 32'h0000_0200};
        @(posedge sys_clk); #1;
        {core_dreq, core_ireq, core_instr_sequential, core_data_burst_lookahead, core_dspec, bus_cycle_enable, core_withdraw} = 7'h01;
        chk({instr_request_n, data_request_n, instr_sequential, data_burst_lookahead, data_speculative_n}, 5'h06);
        @(posedge sys_clk); #1;
        chk({instr_request_n, data_request_n, data_sequential, instr_sequential, data_burst_lookahead}, 5'h18);
        chk({data_speculative_n, core_accept}, 2'h2);
        chk(data_address ^ instr_address, 32'h0000_0300);
        {bus_cycle_enable, core_withdraw} = 2'h2;
        repeat (3) begin
            @(posedge sys_clk); #1;
            chk({core_accept, core_rvalid}, 2'h2);
        end
        $display("withdrawal done");
    endtask

    initial begin
        {sys_rst, bus_cycle_enable, core_dsize, core_wdata} = {2'h3, CBW_SIZE_WORD, WD};
        {core_ireq, core_instr_sequential, core_dreq, core_data_sequential, core_dcop, core_dwrite} = 6'h0;
        {core_data_burst_lookahead, core_dspec, core_withdraw, endian_select, core_iaddr, core_daddr} = '0;
        repeat (6) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        chk({instr_request_n, data_request_n, data_sequential, data_burst_lookahead}, 4'hc);
        chk({data_speculative_n, data_size}, {1'b1, CBW_SIZE_WORD});
        chk(data_address | instr_address | wdata, 32'h0);
        $display("reset values done");
        t_lanes;
        t_types;
        t_withdraw;
        finish_test;
    end
endmodule
